// *** design/grate_bank_if.sv ***
// Carrier between the register front end and the word bank.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface grate_bank_if;
  import grate_pkg::*;
  logic wr_en;
  grate_rate_t [2:0] wr_rate;
  logic rd_en;
  grate_idx_t rd_idx;
  grate_word_t rd_word;
  modport ctrl (output wr_en, output wr_rate, output rd_en, output rd_idx, input rd_word);
  modport bank (input wr_en, input wr_rate, input rd_en, input rd_idx, output rd_word);
endinterface

// *** design/grate_map.svh ***
// Offsets, field positions, reset values and scale for the gyro rate output register set.
// Assumes byte addressing on the serial register port, one byte per access.
`ifndef GRATE_MAP_SVH
`define GRATE_MAP_SVH

`define GRATE_X_LOWER_OFS 7'h04
`define GRATE_X_UPPER_OFS 7'h06
`define GRATE_Y_LOWER_OFS 7'h08
`define GRATE_Y_UPPER_OFS 7'h0a
`define GRATE_Z_LOWER_OFS 7'h0c
`define GRATE_Z_UPPER_OFS 7'h0e
`define GRATE_FIRST_OFS 7'h04
`define GRATE_LAST_OFS 7'h0f

// Field positions inside the combined 32-bit rate
`define GRATE_UPPER_MSB 31
`define GRATE_UPPER_LSB 16
`define GRATE_LOWER_MSB 15
`define GRATE_LOWER_LSB 0

// Zero rate encoding and value shown on unmapped bytes
`define GRATE_WORD_RST 16'h0000
`define GRATE_UNMAPPED_BYTE 8'h00

// Upper-word scale in micro-degrees per second per LSB (0.005 deg/s)
`define GRATE_KG_UDPS 5000

// Cycles from a taken read request to its answer
`define GRATE_READ_LAT 2

`endif

// *** design/grate_out_regs.sv ***
// Gyro angular rate output registers: three axes, upper and lower word each, byte reads.
// Assumes the serial front end on clk_sys issues byte reads and the rate path delivers
// calibrated 32-bit samples with a one-cycle valid strobe.
// A read is answered two edges after it is taken; the byte then holds until the next answer.
// The bank is read on the taking edge, so a sample landing on that edge is not seen yet.
// Unmapped bytes read as zero instead of aliasing into the words, at the cost of a compare.
`timescale 1ns/10ps
`include "grate_map.svh"
module grate_out_regs
  import grate_pkg::*;
(
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic smp_valid, // New processed sample, one cycle
  input wire grate_rate_t [2:0] smp_rate, // Combined 32-bit rates, index 0 = x
  input wire logic rd_req, // Byte read request, one cycle
  input wire grate_addr_t rd_addr, // Byte address of the read
  output logic [7:0] rd_data, // Read byte, holds until the next answer
  output logic rd_ack // Read answer, one cycle
);
  grate_bank_if bus ();

  logic rd_hit;
  grate_addr_t rd_rel;
  logic pend_reg;
  logic hit_reg;
  logic sel_hi_reg;
  logic [7:0] rd_data_reg;
  logic rd_ack_reg;

  grate_word_bank u_bank (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .bus(bus)
  );

  // Samples go straight to the bank; all axes load together
  assign bus.wr_en = smp_valid;
  assign bus.wr_rate = smp_rate;

  // Decode: only the twelve bytes of the six rate words are mapped, none writable
  assign rd_hit = (rd_addr >= `GRATE_FIRST_OFS) && (rd_addr <= `GRATE_LAST_OFS);
  assign rd_rel = rd_addr - `GRATE_FIRST_OFS;
  // Word index: even index lower word, odd index upper word of axis index/2
  assign bus.rd_idx = rd_rel[3:1];
  assign bus.rd_en = rd_req && rd_hit;

  // First stage remembers which byte and whether the access was mapped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_reg <= 1'b0;
      hit_reg <= 1'b0;
      sel_hi_reg <= 1'b0;
    end else begin
      pend_reg <= rd_req;
      hit_reg <= rd_hit;
      sel_hi_reg <= rd_addr[0];
    end
  end

  // Second stage picks the byte; unmapped bytes read as zero rather than aliasing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_reg <= `GRATE_UNMAPPED_BYTE;
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= pend_reg;
      if (pend_reg) begin
        if (!hit_reg) begin
          rd_data_reg <= `GRATE_UNMAPPED_BYTE;
        end else if (sel_hi_reg) begin
          rd_data_reg <= bus.rd_word[15:8];
        end else begin
          rd_data_reg <= bus.rd_word[7:0];
        end
      end
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_ack = rd_ack_reg;

  // Helper shadow of the last sample, read only by the checks below
  grate_rate_t [2:0] shadow_reg;
  grate_word_t exp_word;
  logic [7:0] exp_byte;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shadow_reg <= '0;
    end else if (smp_valid) begin
      shadow_reg <= smp_rate;
    end
  end
  always_comb begin
    exp_word = rd_rel[1] ? shadow_reg[rd_rel[3:2]][31:16] : shadow_reg[rd_rel[3:2]][15:0];
    if (rd_rel[3:2] == 2'h3) begin
      exp_word = 16'h0000;
    end
    exp_byte = rd_addr[0] ? exp_word[15:8] : exp_word[7:0];
  end

  sequence s_read_upper;
    rd_req && rd_hit && rd_rel[1];
  endsequence
  sequence s_read_lower;
    rd_req && rd_hit && !rd_rel[1];
  endsequence

  property p_ack_lat;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_req |-> ##2 rd_ack;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("read answer not two cycles later");

  // No answer without a request, so each access moves exactly one byte
  property p_ack_only;
    @(posedge clk_sys) disable iff (sys_rst)
    !rd_req |-> ##2 !rd_ack;
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("read answer without request");

  property p_upper_map;
    @(posedge clk_sys) disable iff (sys_rst)
    s_read_upper |-> ##2 rd_data == $past(exp_byte, 2);
  endproperty
  a_upper_map: assert property (p_upper_map) else $error("upper word byte wrong");

  property p_lower_map;
    @(posedge clk_sys) disable iff (sys_rst)
    s_read_lower |-> ##2 rd_data == $past(exp_byte, 2);
  endproperty
  a_lower_map: assert property (p_lower_map) else $error("lower word byte wrong");

  property p_unmapped;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_req && !rd_hit |-> ##2 rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped byte not zero");

  sequence s_zero_x;
    smp_valid && (smp_rate[0][31:16] == 16'h0000)
      ##1 (rd_req && !smp_valid && (rd_addr[6:1] == `GRATE_X_UPPER_OFS >> 1));
  endsequence
  property p_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    s_zero_x |-> ##2 rd_data == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("zero rate not read as zero");

  // The read byte only moves with its answer strobe, so a slow host may pick it up late
  property p_data_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    !rd_ack |-> $stable(rd_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read byte moved without answer");

  // Reset leaves the read port quiet; no disable here, reset is the antecedent
  property p_reset_quiet;
    @(posedge clk_sys)
    sys_rst |=> !rd_ack && (rd_data == `GRATE_UNMAPPED_BYTE);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("read port busy after reset");

  // Only the six word slots of the bank are ever addressed
  property p_bank_idx;
    @(posedge clk_sys) disable iff (sys_rst)
    bus.rd_en |-> (bus.rd_idx < 3'h6);
  endproperty
  a_bank_idx: assert property (p_bank_idx) else $error("bank index beyond six words");

  // Per-axis byte checks built from the offset map alone, so a slip in the index
  // decode above cannot hide behind a matching slip in the expected value
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis_chk
      // Word offsets of this axis, picked from the map at elaboration
      localparam grate_addr_t up_ofs = (ax == 0) ? `GRATE_X_UPPER_OFS
        : (ax == 1) ? `GRATE_Y_UPPER_OFS : `GRATE_Z_UPPER_OFS;
      localparam grate_addr_t lo_ofs = (ax == 0) ? `GRATE_X_LOWER_OFS
        : (ax == 1) ? `GRATE_Y_LOWER_OFS : `GRATE_Z_LOWER_OFS;

      sequence s_take_upper;
        rd_req && (rd_addr[6:1] == up_ofs[6:1]);
      endsequence
      sequence s_take_lower;
        rd_req && (rd_addr[6:1] == lo_ofs[6:1]);
      endsequence

      // Upper word carries the top half of the sample, low byte at the even address
      property p_axis_upper;
        @(posedge clk_sys) disable iff (sys_rst)
        s_take_upper |-> ##2
          rd_data == $past(rd_addr[0] ? shadow_reg[ax][31:24] : shadow_reg[ax][23:16], 2);
      endproperty
      a_axis_upper: assert property (p_axis_upper) else $error("axis upper byte wrong");

      // Lower word carries the grown bits, the bottom half of the same sample
      property p_axis_lower;
        @(posedge clk_sys) disable iff (sys_rst)
        s_take_lower |-> ##2
          rd_data == $past(rd_addr[0] ? shadow_reg[ax][15:8] : shadow_reg[ax][7:0], 2);
      endproperty
      a_axis_lower: assert property (p_axis_lower) else $error("axis lower byte wrong");

      // A zero rate on any axis reads as zero in both bytes of its upper word
      property p_axis_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        s_take_upper && (shadow_reg[ax][31:16] == 16'h0000) |-> ##2 rd_data == 8'h00;
      endproperty
      a_axis_zero: assert property (p_axis_zero) else $error("axis zero rate not zero");
    end
  endgenerate
endmodule

// *** design/grate_pkg.sv ***
// Types shared by the gyro rate output register set.
// Assumes the constants header is included where offsets are needed.
package grate_pkg;
  typedef logic [31:0] grate_rate_t;
  typedef logic [15:0] grate_word_t;
  typedef logic [2:0] grate_idx_t;
  typedef logic [6:0] grate_addr_t;
endpackage

// *** design/grate_word_bank.sv ***
// Six-word store of the rate registers with a registered read port.
// Assumes writes carry all three axes at once and reads name a word index 0..5.
`timescale 1ns/10ps
`include "grate_map.svh"
module grate_word_bank
  import grate_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  grate_bank_if.bank bus // Write and read port
);
  grate_word_t words [6];
  grate_word_t rd_word_reg;

  // Both halves of an axis load on the same edge, so a pair never mixes samples
  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          words[2*a] <= `GRATE_WORD_RST;
          words[2*a+1] <= `GRATE_WORD_RST;
        end else if (bus.wr_en) begin
          words[2*a] <= bus.wr_rate[a][`GRATE_LOWER_MSB:`GRATE_LOWER_LSB];
          words[2*a+1] <= bus.wr_rate[a][`GRATE_UPPER_MSB:`GRATE_UPPER_LSB];
        end
      end

      property p_split;
        @(posedge clk_sys) disable iff (sys_rst)
        bus.wr_en |=> (words[2*a+1] == $past(bus.wr_rate[a][31:16]))
                   && (words[2*a] == $past(bus.wr_rate[a][15:0]));
      endproperty
      a_split: assert property (p_split) else $error("rate halves not split from sample");

      property p_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        !bus.wr_en |=> $stable(words[2*a]) && $stable(words[2*a+1]);
      endproperty
      a_hold: assert property (p_hold) else $error("rate word changed without sample");
    end
  endgenerate

  // Read before write: a read on the sample edge returns the previous pair
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_word_reg <= `GRATE_WORD_RST;
    end else if (bus.rd_en) begin
      rd_word_reg <= (bus.rd_idx < 3'h6) ? words[bus.rd_idx] : `GRATE_WORD_RST;
    end
  end

  assign bus.rd_word = rd_word_reg;

  property p_read;
    @(posedge clk_sys) disable iff (sys_rst)
    bus.rd_en && (bus.rd_idx < 3'h6) && !bus.wr_en |=> rd_word_reg == $past(words[bus.rd_idx]);
  endproperty
  a_read: assert property (p_read) else $error("bank read returned wrong word");
endmodule

// *** tb/grate_host_model.sv ***
// Host that reads the rate registers one byte per access.
// Assumes it is called just after a rising edge of clk_sys.
`timescale 1ns/10ps
`include "grate_map.svh"
module grate_host_model
  import grate_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rd_ack, // Read answer
  input wire logic [7:0] rd_data, // Read byte
  output logic rd_req, // Byte read request
  output grate_addr_t rd_addr // Byte address
);
  initial begin
    rd_req = 1'b0;
    rd_addr = 7'h00;
  end
  // One byte per access; n counts edges from take to answer, bounded so a lost ack shows
  task automatic read_byte(input grate_addr_t a, output logic [7:0] d, output int n);
    logic got;
    rd_req = 1'b1;
    rd_addr = a;
    @(posedge clk_sys);
    #1;
    rd_req = 1'b0;
    n = 0;
    d = 8'hxx;
    got = 1'b0;
    // Look mid-cycle where the answer is settled, then count the edge that takes it
    while (n < 8 && !got) begin
      @(negedge clk_sys);
      if (rd_ack === 1'b1) begin
        got = 1'b1;
        d = rd_data;
      end
      @(posedge clk_sys);
      n++;
    end
    #1;
  endtask
  // Low byte at the word address, high byte at plus one
  task automatic read_word(input grate_addr_t a, output grate_word_t w);
    logic [7:0] lo;
    logic [7:0] hi;
    int n;
    read_byte(a, lo, n);
    read_byte(a + 7'h01, hi, n);
    w = {hi, lo};
  endtask
  // Top four lower bits go below the full upper word, sign stays on top
  function automatic logic [19:0] combine20(grate_word_t up, grate_word_t low);
    return {up, low[15:12]};
  endfunction
  // Weight of one LSB in nano-degrees per second when nbits are kept
  function automatic int lsb_ndps(int nbits);
    return (`GRATE_KG_UDPS * 1000) >> (nbits - 16);
  endfunction
endmodule

// *** tb/grate_out_regs_bench.sv ***
// Bench for the gyro rate output registers: loads samples, reads every byte back.
// Assumes the host model owns the read port and the bench the sample port.
`timescale 1ns/10ps
module grate_out_regs_bench;
  import grate_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic smp_valid = 1'b0;
  grate_rate_t [2:0] smp_rate = '0;
  logic rd_req;
  grate_addr_t rd_addr;
  logic [7:0] rd_data;
  logic rd_ack;
  int err_count = 0;
  int checked = 0;
  grate_rate_t [2:0] cur;
  grate_word_t wu;
  grate_word_t wl;
  logic [7:0] b;
  int n;
  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;
  grate_out_regs u_grate_out_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .smp_valid(smp_valid), .smp_rate(smp_rate), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack));
  grate_host_model u_grate_host_model (.clk_sys(clk_sys), .rd_ack(rd_ack),
    .rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr));
  task automatic wrap_up();
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp20(string what, logic [19:0] exp, logic [19:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle sample strobe, called just after an edge
  task automatic load(grate_rate_t [2:0] v);
    smp_rate = v;
    smp_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    smp_valid = 1'b0;
  endtask
  // Every byte 0x00..0x13 plus the top address; unmapped ones read zero
  task automatic sweep();
    logic [7:0] e;
    for (int a = 0; a < 21; a++) begin
      grate_addr_t ad;
      ad = (a == 20) ? 7'h7f : 7'(a);
      e = (ad < 7'h04 || ad > 7'h0f) ? 8'h00 : cur[(ad - 7'h04) >> 2][ad[1:0] * 8 +: 8];
      u_grate_host_model.read_byte(ad, b, n);
      cmp8("read byte", e, b);
      cmp8("read latency", 8'h02, 8'(n));
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    cur = '0;
    sweep();
    cur = {32'hffff_8001, 32'hb1e0_1234, 32'h4e20_a5c3};
    load(cur);
    sweep();
    // A read taken with a new sample must still return the old one
    fork
      load({32'h0001_f000, 32'h0000_0000, 32'hb1e0_0abc});
      u_grate_host_model.read_byte(7'h07, b, n);
    join
    cmp8("same edge read", 8'h4e, b);
    cur = {32'h0001_f000, 32'h0000_0000, 32'hb1e0_0abc};
    sweep();
    u_grate_host_model.read_word(7'h06, wu);
    u_grate_host_model.read_word(7'h04, wl);
    cmp20("x 20 bit", 20'hb1e00, u_grate_host_model.combine20(wu, wl));
    u_grate_host_model.read_word(7'h0e, wu);
    u_grate_host_model.read_word(7'h0c, wl);
    cmp20("z 20 bit", 20'h0001f, u_grate_host_model.combine20(wu, wl));
    cmp20("lsb 20 bit", 20'h4c4b4, 20'(u_grate_host_model.lsb_ndps(20)));
    // A zero rate read on the cycle right after its sample
    load({32'h0001_f000, 32'h0000_0000, 32'h0000_7777});
    u_grate_host_model.read_byte(7'h06, b, n);
    cmp8("x upper zero", 8'h00, b);
    u_grate_host_model.read_byte(7'h04, b, n);
    cmp8("x lower after zero", 8'h77, b);
    wrap_up();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule
